// ==== sbr_cal_strobe.sv ====
// strip readout package and calibration strobe generator
`timescale 1ns/1ps

package sbr_pkg;
  localparam int NCH = 128;
  localparam int PIPE_DEPTH = 32;
  localparam int PIPE_AW = 5;
  localparam logic [4:0] TRIG_LATENCY = 5'h10;
  localparam int BUF_DEPTH = 8;
  localparam logic [3:0] BUF_FULL = 4'h8;
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_TRIM = 8'h0c;
  localparam int CFG_EDGE = 0;
  localparam int CFG_THREXT = 1;
  localparam int CFG_RANGE_LO = 2;
  localparam int CFG_AMP_LO = 4;
  localparam int CFG_DLY_LO = 12;
  localparam int CFG_BYP = 18;
  localparam int CFG_ID_LO = 19;
  localparam int CMD_FIRE = 0;
  localparam int CMD_GRP_LO = 1;
  localparam int TRIM_VAL_LO = 8;
  // arbitrary identifier value
  localparam logic [6:0] CHIP_ID_DEFAULT = 7'h2a;
  localparam logic [31:0] CFG_RESET = {6'h00, CHIP_ID_DEFAULT, 19'h00000};
  localparam logic [5:0] CAL_WIDTH = 6'h02;
  localparam logic [3:0] HDR_LAST = 4'hb;
  localparam logic [3:0] HIT_LAST = 4'ha;
  localparam logic [6:0] LAST_CHAN = 7'h7f;
  typedef enum logic [2:0] {S_IDLE, S_HDR, S_SCAN, S_HIT, S_TRAIL} sbr_rd_state_t;
endpackage : sbr_pkg

module sbr_cal_strobe (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic fire,
  input wire logic [1:0] groupIn,
  input wire logic [5:0] delay,
  output logic calStrobe,
  output logic calGroupSelBit0,
  output logic calGroupSelBit1,
  output logic busy
);
  import sbr_pkg::*;

  logic [5:0] cnt_reg;
  logic busy_reg;
  logic strobe_reg;
  logic [1:0] grp_reg;
  wire idle = !busy_reg && !strobe_reg;

  // ----------------------------------------
  // delay then fixed-width strobe
  // ----------------------------------------
  // a command while a strobe is pending is dropped, so groups never mix
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg <= 6'h00;
      busy_reg <= 1'b0;
      strobe_reg <= 1'b0;
      grp_reg <= 2'h0;
    end else if (idle && fire) begin
      busy_reg <= 1'b1;
      cnt_reg <= delay;
      grp_reg <= groupIn;
    end else if (busy_reg) begin
      if (cnt_reg == 6'h00) begin
        busy_reg <= 1'b0;
        strobe_reg <= 1'b1;
        cnt_reg <= CAL_WIDTH - 6'h01;
      end else begin
        cnt_reg <= cnt_reg - 6'h01;
      end
    end else if (strobe_reg) begin
      if (cnt_reg == 6'h00) begin
        strobe_reg <= 1'b0;
      end else begin
        cnt_reg <= cnt_reg - 6'h01;
      end
    end
  end

  assign calStrobe = strobe_reg;
  assign calGroupSelBit0 = grp_reg[0];
  assign calGroupSelBit1 = grp_reg[1];
  assign busy = busy_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence fireIdleZero;
    idle && fire && delay == 6'h00;
  endsequence

  a_strobe_zero_delay: assert property (@(posedge clk) disable iff (sys_rst)
    fireIdleZero |=> ##1 calStrobe) else $error("strobe late for zero delay");
  a_strobe_from_cmd: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(calStrobe) |-> $past(busy_reg)) else $error("strobe without command");
  a_strobe_width: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(calStrobe) |=> calStrobe ##1 !calStrobe) else $error("strobe width wrong");
  a_group_stable: assert property (@(posedge clk) disable iff (sys_rst)
    calStrobe |-> $stable({calGroupSelBit1, calGroupSelBit0})) else $error("group moved");
endmodule : sbr_cal_strobe

// ==== sbr_ctrl_model.sv ====
// readout controller model: accept triggers and token reads
`timescale 1ns/1ps
module sbr_ctrl_model (
  input wire logic clk,
  input wire logic dataOut,
  input wire logic dataOutValid,
  input wire logic tokenOut,
  output logic acceptTrigger,
  output logic tokenIn
);
  logic frame[$];
  logic granted;
  int protoErrs;
  int gotToken;
  initial begin
    acceptTrigger = 1'b0;
    tokenIn = 1'b0;
    granted = 1'b0;
    protoErrs = 0;
    gotToken = 0;
  end
  // any bit seen while the token is with us is a protocol slip
  always @(posedge clk) begin
    if (dataOutValid === 1'b1 && !granted) protoErrs++;
  end
  // long high and low times so the synchroniser sees one clean edge
  task automatic trigger();
    @(posedge clk) acceptTrigger <= 1'b1;
    repeat (6) @(posedge clk);
    acceptTrigger <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : trigger
  task automatic read_event();
    int n;
    frame.delete();
    gotToken = 0;
    @(posedge clk) tokenIn <= 1'b1;
    granted = 1'b1;
    for (n = 0; n < 3000 && gotToken == 0; n++) begin
      @(posedge clk);
      if (dataOutValid === 1'b1) frame.push_back(dataOut);
      if (tokenOut === 1'b1) gotToken = 1;
    end
    granted = 1'b0;
    tokenIn <= 1'b0;
    repeat (5) @(posedge clk);
  endtask : read_event
endmodule : sbr_ctrl_model

// ==== sbr_readout_core.sv ====
// strip binary readout core: pipeline, derandomizer, serial readout, apb registers
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps

module sbr_readout_core (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [sbr_pkg::NCH-1:0] hitIn,
  input wire logic acceptTrigger,
  input wire logic tokenIn,
  output logic tokenOut,
  output logic dataOut,
  output logic dataOutValid,
  output logic calStrobe,
  output logic calGroupSelBit0,
  output logic calGroupSelBit1,
  output logic [7:0] calAmplitude,
  output logic thresholdExternal,
  output logic [1:0] trimRange,
  output logic [4*sbr_pkg::NCH-1:0] trimSettings
);
  import sbr_pkg::*;

  function automatic logic [NCH-1:0] filt(input logic [NCH-1:0] a, input logic [NCH-1:0] b,
                                          input logic [NCH-1:0] held);
    filt = (a & b) | (held & (a | b));
  endfunction : filt

  function automatic logic [2:0] chanBits(input logic [3*NCH-1:0] e, input logic [6:0] c);
    chanBits = {e[{2'b10, c}], e[{2'b01, c}], e[{2'b00, c}]};
  endfunction : chanBits

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [NCH-1:0] hitS1_reg, hitS2_reg, hitS3_reg, hitAcc_reg, hitPrev_reg;
  logic [NCH-1:0] ctlS1_reg, ctlS2_reg, ctlS3_reg, ctlAcc_reg, ctlPrev_reg;
  wire [NCH-1:0] ctlPins = {{(NCH-2){1'b0}}, tokenIn, acceptTrigger};
  // a change counts only once the second and third stages agree
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {hitS1_reg, hitS2_reg, hitS3_reg, hitAcc_reg, hitPrev_reg} <= '0;
      {ctlS1_reg, ctlS2_reg, ctlS3_reg, ctlAcc_reg, ctlPrev_reg} <= '0;
    end else begin
      {hitS1_reg, hitS2_reg, hitS3_reg} <= {hitIn, hitS1_reg, hitS2_reg};
      hitAcc_reg <= filt(hitS2_reg, hitS3_reg, hitAcc_reg);
      hitPrev_reg <= hitAcc_reg;
      {ctlS1_reg, ctlS2_reg, ctlS3_reg} <= {ctlPins, ctlS1_reg, ctlS2_reg};
      ctlAcc_reg <= filt(ctlS2_reg, ctlS3_reg, ctlAcc_reg);
      ctlPrev_reg <= ctlAcc_reg;
    end
  end
  wire trigRise = ctlAcc_reg[0] && !ctlPrev_reg[0];
  wire tokenRise = ctlAcc_reg[1] && !ctlPrev_reg[1];

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [31:0] cfg_reg;
  logic [6:0] trimAddr_reg;
  logic [4*NCH-1:0] trim_reg;
  logic [31:0] prdata_reg;
  logic pready_reg, pslverr_reg;
  logic cfgErr_reg, ovfErr_reg, trackErr_reg;
  logic [3:0] count_reg;
  sbr_rd_state_t state_reg;

  wire edgeEn = cfg_reg[CFG_EDGE];
  wire bypassEn = cfg_reg[CFG_BYP];
  wire [6:0] chip_identifier = cfg_reg[CFG_ID_LO +: 7];
  wire accessNow = psel && penable && !pready_reg;
  wire doneNow = psel && penable && pready_reg;
  wire hitCfg = paddr == OFS_CFG;
  wire hitCmd = paddr == OFS_CMD;
  wire hitStat = paddr == OFS_STAT;
  wire hitTrim = paddr == OFS_TRIM;
  wire mapped = hitCfg || hitCmd || hitStat || hitTrim;
  wire wrDone = doneNow && pwrite;
  wire calFire = wrDone && hitCmd && pwdata[CMD_FIRE];
  wire cfgErrSet = wrDone && !mapped;
  wire [3:0] trimRead = trim_reg[{trimAddr_reg, 2'b00} +: 4];
  wire [31:0] statWord = {24'h000000, state_reg != S_IDLE, count_reg, trackErr_reg,
                          cfgErr_reg, ovfErr_reg};
  wire [31:0] readMux = hitCfg ? cfg_reg :
                        hitStat ? statWord :
                        hitTrim ? {20'h00000, trimRead, 1'b0, trimAddr_reg} : 32'h00000000;

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= accessNow;
      pslverr_reg <= accessNow && !mapped;
      prdata_reg <= accessNow && !pwrite ? readMux : 32'h00000000;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_reg <= CFG_RESET;
      trimAddr_reg <= 7'h00;
      trim_reg <= '0;
    end else if (wrDone && hitCfg) begin
      cfg_reg <= pwdata;
    end else if (wrDone && hitTrim) begin
      trimAddr_reg <= pwdata[6:0];
      trim_reg[{pwdata[6:0], 2'b00} +: 4] <= pwdata[TRIM_VAL_LO +: 4];
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign thresholdExternal = cfg_reg[CFG_THREXT];
  assign trimRange = cfg_reg[CFG_RANGE_LO +: 2];
  assign calAmplitude = cfg_reg[CFG_AMP_LO +: 8];
  assign trimSettings = trim_reg;

  // ----------------------------------------
  // pipeline
  // ----------------------------------------
  // depth must stay above the trigger latency plus one neighbour slot
  logic [NCH-1:0] pipeMem [PIPE_DEPTH];
  logic [PIPE_AW-1:0] pipeWr_reg;
  wire [NCH-1:0] pipeIn = edgeEn ? hitAcc_reg & ~hitPrev_reg : hitAcc_reg;
  wire [PIPE_AW-1:0] slot = pipeWr_reg - TRIG_LATENCY;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pipeWr_reg <= '0;
    end else begin
      pipeWr_reg <= pipeWr_reg + 5'h01;
    end
  end
  always_ff @(posedge clk) begin
    pipeMem[pipeWr_reg] <= pipeIn;
  end

  // ----------------------------------------
  // derandomizer
  // ----------------------------------------
  logic [3*NCH-1:0] bufMem [BUF_DEPTH];
  logic [3:0] wr_reg, rd_reg;
  logic hadEvt_reg;
  wire full = count_reg == BUF_FULL;
  wire pop = state_reg == S_TRAIL && hadEvt_reg;
  wire overwrite = trigRise && full && !pop;
  wire [3*NCH-1:0] ev = bufMem[rd_reg[2:0]];
  wire hdrLoad = state_reg == S_IDLE && tokenRise && !bypassEn;

  always_ff @(posedge clk) begin
    if (trigRise) begin
      bufMem[wr_reg[2:0]] <= {pipeMem[slot + 5'h01], pipeMem[slot], pipeMem[slot - 5'h01]};
    end
  end

  // an overwrite during readout corrupts the event being sent; accepted cost
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_reg <= 4'h0;
      rd_reg <= 4'h0;
      count_reg <= 4'h0;
    end else begin
      wr_reg <= wr_reg + {3'h0, trigRise};
      rd_reg <= rd_reg + {3'h0, pop} + {3'h0, overwrite};
      if (trigRise && !pop && !full) begin
        count_reg <= count_reg + 4'h1;
      end else if (pop && !trigRise) begin
        count_reg <= count_reg - 4'h1;
      end
    end
  end

  // set wins over the clear made by sending a header
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ovfErr_reg <= 1'b0;
      cfgErr_reg <= 1'b0;
      trackErr_reg <= 1'b0;
    end else begin
      ovfErr_reg <= overwrite || (ovfErr_reg && !hdrLoad);
      cfgErr_reg <= cfgErrSet || (cfgErr_reg && !hdrLoad);
      trackErr_reg <= trackErr_reg || (wr_reg - rd_reg != count_reg);
    end
  end

  // ----------------------------------------
  // token readout
  // ----------------------------------------
  logic [11:0] shift_reg;
  logic [3:0] bitCnt_reg;
  logic [6:0] chan_reg;
  logic valid_reg, tokenOut_reg;
  wire [2:0] curBits = chanBits(ev, chan_reg);
  wire empty = count_reg == 4'h0;
  wire [11:0] header = {1'b1, trackErr_reg, cfgErr_reg, ovfErr_reg, empty, chip_identifier};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= S_IDLE;
      shift_reg <= 12'h000;
      bitCnt_reg <= 4'h0;
      chan_reg <= 7'h00;
      valid_reg <= 1'b0;
      tokenOut_reg <= 1'b0;
      hadEvt_reg <= 1'b0;
    end else begin
      tokenOut_reg <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          valid_reg <= 1'b0;
          if (tokenRise && bypassEn) begin
            tokenOut_reg <= 1'b1;
          end else if (tokenRise) begin
            shift_reg <= header;
            bitCnt_reg <= HDR_LAST;
            chan_reg <= 7'h00;
            hadEvt_reg <= !empty;
            valid_reg <= 1'b1;
            state_reg <= S_HDR;
          end
        end
        S_HDR, S_HIT: begin
          shift_reg <= {shift_reg[10:0], 1'b0};
          bitCnt_reg <= bitCnt_reg - 4'h1;
          if (bitCnt_reg == 4'h0) begin
            valid_reg <= !hadEvt_reg || chan_reg == LAST_CHAN;
            shift_reg <= 12'h000;
            if (state_reg == S_HDR && hadEvt_reg) begin
              state_reg <= S_SCAN;
            end else if (!hadEvt_reg || chan_reg == LAST_CHAN) begin
              state_reg <= S_TRAIL;
            end else begin
              chan_reg <= chan_reg + 7'h01;
              state_reg <= S_SCAN;
            end
          end
        end
        S_SCAN: begin
          if (curBits != 3'h0) begin
            shift_reg <= {1'b1, chan_reg, curBits, 1'b0};
            bitCnt_reg <= HIT_LAST;
            valid_reg <= 1'b1;
            state_reg <= S_HIT;
          end else if (chan_reg == LAST_CHAN) begin
            shift_reg <= 12'h000;
            valid_reg <= 1'b1;
            state_reg <= S_TRAIL;
          end else begin
            chan_reg <= chan_reg + 7'h01;
          end
        end
        S_TRAIL: begin
          valid_reg <= 1'b0;
          tokenOut_reg <= 1'b1;
          state_reg <= S_IDLE;
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  assign dataOut = shift_reg[11];
  assign dataOutValid = valid_reg;
  assign tokenOut = tokenOut_reg;

  // ----------------------------------------
  // calibration strobe
  // ----------------------------------------
  sbr_cal_strobe u_cal (
    .clk(clk),
    .sys_rst(sys_rst),
    .fire(calFire),
    .groupIn(pwdata[CMD_GRP_LO +: 2]),
    .delay(cfg_reg[CFG_DLY_LO +: 6]),
    .calStrobe(calStrobe),
    .calGroupSelBit0(calGroupSelBit0),
    .calGroupSelBit1(calGroupSelBit1),
    .busy()
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence tokenEmpty;
    hdrLoad && empty;
  endsequence

  a_edge_single_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    edgeEn && pipeIn != '0 |=> (pipeIn & $past(pipeIn)) == '0 || !$stable(edgeEn))
    else $error("edge pulse too long");
  a_level_follows: assert property (@(posedge clk) disable iff (sys_rst)
    !edgeEn |-> pipeIn == hitAcc_reg) else $error("level capture mismatch");
  a_pipe_advance: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) |-> pipeWr_reg == $past(pipeWr_reg) + 5'h01) else $error("pipeline stalled");
  a_trig_stores: assert property (@(posedge clk) disable iff (sys_rst)
    trigRise && !full && !pop |=> count_reg == $past(count_reg) + 4'h1) else $error("no store");
  a_nodata_report: assert property (@(posedge clk) disable iff (sys_rst)
    tokenEmpty |=> dataOutValid && shift_reg[7] ##13 tokenOut) else $error("no-data not sent");
  a_overflow_flag: assert property (@(posedge clk) disable iff (sys_rst)
    overwrite |=> ovfErr_reg && count_reg == BUF_FULL) else $error("overflow not flagged");
  a_track_sticky: assert property (@(posedge clk) disable iff (sys_rst)
    trackErr_reg |=> trackErr_reg) else $error("tracking error released");
  a_cfg_err_id: assert property (@(posedge clk) disable iff (sys_rst)
    cfgErrSet |=> cfgErr_reg ##[0:3] !pready) else $error("config error missed");
  a_bypass_token: assert property (@(posedge clk) disable iff (sys_rst)
    state_reg == S_IDLE && tokenRise && bypassEn |=> tokenOut && !dataOutValid)
    else $error("bypass token lost");
  a_send_with_token: assert property (@(posedge clk) disable iff (sys_rst)
    dataOutValid |-> state_reg != S_IDLE || $past(state_reg) == S_TRAIL)
    else $error("data without token");
endmodule : sbr_readout_core

// ==== sbr_tb.sv ====
// self-checking bench for the strip readout core
`timescale 1ns/1ps
module tb;
  import sbr_pkg::*;
  // ------
  // signals
  // ------
  logic clk, sysRst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, calAmplitude;
  logic [31:0] pwdata, prdata, rd;
  logic [NCH-1:0] hitIn;
  logic acceptTrigger, tokenIn, tokenOut, dataOut, dataOutValid, calStrobe;
  logic calGroupSelBit0, calGroupSelBit1, thresholdExternal;
  logic [1:0] trimRange;
  logic [4*NCH-1:0] trimSettings;
  logic [10:0] noRecs[$];
  logic [10:0] hitRecs[$];
  int mismatches = 0;
  int samples_checked = 0;
  sbr_readout_core sbr_readout_core_i (.clk(clk), .sys_rst(sysRst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hitIn(hitIn), .acceptTrigger(acceptTrigger),
    .tokenIn(tokenIn), .tokenOut(tokenOut), .dataOut(dataOut), .dataOutValid(dataOutValid),
    .calStrobe(calStrobe), .calGroupSelBit0(calGroupSelBit0),
    .calGroupSelBit1(calGroupSelBit1), .calAmplitude(calAmplitude),
    .thresholdExternal(thresholdExternal), .trimRange(trimRange),
    .trimSettings(trimSettings));
  sbr_ctrl_model ctrl_i (.clk(clk), .dataOut(dataOut), .dataOutValid(dataOutValid),
    .tokenOut(tokenOut), .acceptTrigger(acceptTrigger), .tokenIn(tokenIn));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ------
  // shared tasks
  // ------
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up
  // no cycle count assumed: waits on pready, watchdog covers a hang
  task automatic apb(logic wr, logic [7:0] addr, logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic [31:0] cfgWord(logic edgeMode, logic ext, logic [1:0] rng,
      logic [7:0] amp, logic [5:0] dly, logic byp);
    return {6'h00, CHIP_ID_DEFAULT, byp, dly, amp, rng, ext, edgeMode};
  endfunction : cfgWord
  // flags are tracking, config, overflow, no-data
  task automatic expect_event(string what, logic [3:0] flags, logic [10:0] recs[$]);
    logic want[$];
    logic [11:0] hdr;
    hdr = {1'b1, flags, CHIP_ID_DEFAULT};
    for (int i = 11; i >= 0; i--) want.push_back(hdr[i]);
    foreach (recs[j]) for (int i = 10; i >= 0; i--) want.push_back(recs[j][i]);
    want.push_back(1'b0);
    ctrl_i.read_event();
    check({what, " token on"}, ctrl_i.gotToken, 1);
    check({what, " bits"}, ctrl_i.frame.size(), want.size());
    for (int i = 0; i < want.size() && i < ctrl_i.frame.size(); i++) begin
      check({what, " bit"}, ctrl_i.frame[i], want[i]);
    end
  endtask : expect_event
  // ------
  // scenarios
  // ------
  task automatic t_regs();
    apb(0, OFS_CFG, 0);
    check("cfg reset", rd, CFG_RESET);
    apb(0, OFS_STAT, 0);
    check("stat reset", rd, 32'h0);
    apb(1, OFS_CFG, cfgWord(0, 1, 2'h2, 8'h5a, 6'h00, 0));
    #1;
    check("threshold source", thresholdExternal, 1'b1);
    check("cal amplitude", calAmplitude, 8'h5a);
    check("trim range", trimRange, 2'h2);
    apb(1, OFS_TRIM, 32'h00000a05);
    apb(1, OFS_TRIM, 32'h0000037f);
    #1;
    check("trim ch5", trimSettings[23:20], 4'ha);
    check("trim ch127", trimSettings[511:508], 4'h3);
    apb(0, OFS_TRIM, 0);
    check("trim read", rd[11:0], 12'h37f);
    apb(1, 8'h10, 0);
    check("unmapped err", err, 1'b1);
    apb(0, OFS_STAT, 0);
    check("cfg error flag", rd[1], 1'b1);
    expect_event("empty", 4'b0101, noRecs);
    expect_event("empty again", 4'b0001, noRecs);
    $display("test regs_and_empty done");
  endtask : t_regs
  task automatic t_cal();
    logic [5:0] dly[4];
    int rise, width, quiet;
    dly = '{6'h00, 6'h02, 6'h11, 6'h3f};
    for (int g = 0; g < 4; g++) begin
      apb(1, OFS_CFG, cfgWord(0, 0, 0, 0, dly[g], 0));
      apb(1, OFS_CMD, 32'h00000006);
      quiet = 1;
      repeat (70) begin
        @(posedge clk);
        #1;
        if (calStrobe !== 1'b0) quiet = 0;
      end
      check("no fire without command", quiet, 1);
      apb(1, OFS_CMD, {29'h0, g[1:0], 1'b1});
      rise = -1;
      width = 0;
      for (int n = 1; n < 75; n++) begin
        @(posedge clk);
        #1;
        if (calStrobe === 1'b1) begin
          if (rise < 0) rise = n;
          width++;
        end
      end
      check("strobe delay", rise, dly[g] + 1);
      check("strobe width", width, CAL_WIDTH);
      check("cal group", {calGroupSelBit1, calGroupSelBit0}, g[1:0]);
    end
    $display("test calibration done");
  endtask : t_cal
  task automatic t_hits();
    apb(1, OFS_CFG, cfgWord(0, 0, 0, 0, 0, 0));
    hitIn[9] <= 1'b1;
    hitIn[127] <= 1'b1;
    repeat (60) @(posedge clk);
    ctrl_i.trigger();
    repeat (40) @(posedge clk);
    hitIn <= '0;
    hitRecs = '{{1'b1, 7'h09, 3'b111}, {1'b1, LAST_CHAN, 3'b111}};
    expect_event("level hits", 4'b0000, hitRecs);
    // a long hit in edge mode leaves nothing far from its edge
    apb(1, OFS_CFG, cfgWord(1, 0, 0, 0, 0, 0));
    hitIn[9] <= 1'b1;
    repeat (60) @(posedge clk);
    ctrl_i.trigger();
    repeat (20) @(posedge clk);
    hitIn <= '0;
    expect_event("edge long hit", 4'b0000, noRecs);
    $display("test hits done");
  endtask : t_hits
  task automatic t_overflow();
    apb(1, OFS_CFG, cfgWord(0, 0, 0, 0, 0, 0));
    repeat (BUF_DEPTH + 1) ctrl_i.trigger();
    apb(0, OFS_STAT, 0);
    check("overflow flag", rd[0], 1'b1);
    check("event count", rd[6:3], BUF_FULL);
    check("tracking ok", rd[2], 1'b0);
    for (int k = 0; k < BUF_DEPTH; k++) begin
      expect_event("drain", (k == 0) ? 4'b0010 : 4'b0000, noRecs);
    end
    apb(0, OFS_STAT, 0);
    check("drained stat", rd[6:0], 7'h00);
    expect_event("after drain", 4'b0001, noRecs);
    $display("test overflow done");
  endtask : t_overflow
  task automatic t_bypass();
    apb(1, OFS_CFG, cfgWord(0, 0, 0, 0, 0, 1));
    ctrl_i.trigger();
    ctrl_i.read_event();
    check("bypass token", ctrl_i.gotToken, 1);
    check("bypass no data", ctrl_i.frame.size(), 0);
    apb(1, OFS_CFG, cfgWord(0, 0, 0, 0, 0, 0));
    expect_event("kept event", 4'b0000, noRecs);
    $display("test bypass done");
  endtask : t_bypass
  initial begin
    sysRst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    hitIn = '0;
    repeat (8) @(posedge clk);
    sysRst <= 1'b0;
    repeat (40) @(posedge clk);
    t_regs();
    t_cal();
    t_hits();
    t_overflow();
    t_bypass();
    check("data outside token", ctrl_i.protoErrs, 0);
    wrap_up();
  end
  // whole run needs well under 8000 cycles
  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    wrap_up();
  end
endmodule : tb
